// ==== src/scp_top.sv ====
// Serializer configuration, power-down control and serial frame output.
`timescale 1ns/1ps
`include "scp_map.svh"
module scp_top
  import scp_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        power_down_n,
  input  wire logic        strobe_edge_select,
  input  wire logic        swing_select,
  input  wire logic        deemphasis_control,
  input  wire logic        parallel_clock_in,
  input  wire logic [23:0] par_data,
  input  wire logic [2:0]  par_ctrl,
  input  wire logic [7:0]  bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [7:0]  bus_rdata,
  output logic             serial_out_p,
  output logic             serial_out_n,
  output logic             pll_enable,
  output logic             link_active,
  output logic             edge_rising,
  output logic             swing_high,
  output logic             deemph_enable
);

  // Lock wait in reference clock cycles; it must fit the eight-bit counter.
  localparam logic [7:0] LOCK_CYC = 8'(`SCP_PLL_LOCK_CYC);

  // =====================================================================
  // State.
  scp_pwr_t   pwr;
  scp_pwr_t   next_pwr;
  logic [7:0] lock_count;
  logic [7:0] ctrl;
  logic [7:0] next_ctrl;
  logic       overrun;
  logic       next_overrun;
  logic [7:0] next_rdata;

  // =====================================================================
  // Submodule outputs.
  scp_word_t cap_word;
  logic      cap_valid;
  logic      ser_bit;
  logic      ser_busy;

  // =====================================================================
  // Decode wires.
  // The pin is used as it stands; it is synchronous to ref_clk, so no
  // extra flip-flop delays the entry into power-down.
  wire powered   = power_down_n;                              // [RQ1]

  // Power state decode.
  wire in_down   = (pwr == scp_down);
  wire in_lock   = (pwr == scp_lock);
  wire in_run    = (pwr == scp_run);
  wire leave_dn  = in_down & powered;
  wire lock_done = in_lock & (lock_count == LOCK_CYC - 8'h01);

  // Register port decode; the bus is deaf until the down state is left,
  // so a write can never race the load from the straps.
  wire bus_live  = powered & ~in_down;
  wire wr_ctrl   = bus_wr & bus_live & (bus_addr == `SCP_ADDR_CTRL);
  wire wr_stat   = bus_wr & bus_live & (bus_addr == `SCP_ADDR_STATUS);

  // Frame path decode; a capture seen while a frame is still shifting is
  // lost rather than queued, since there is no buffer.
  wire run_next  = in_run & powered;
  wire drop      = cap_valid & ser_busy & in_run;
  wire clr_ovr   = wr_stat & bus_wdata[`SCP_ST_OVERRUN];

  // A floating de-emphasis strap is passed on as it stands here, with no pull-down, so it is not read low as off.
  wire strap_de  = deemphasis_control;                         // [RQ10]

  // Pin straps gathered into the control layout.
  wire [7:0] strap_ctrl = {
    5'h00,
    strap_de,                                                  // [RQ11]
    swing_select,                                              // [RQ8]
    strobe_edge_select                                         // [RQ5] [RQ6]
  };

  // =====================================================================
  // Power sequencing.
  // Power-down forces the down state at once; leaving it waits
  // for the PLL to settle before the link carries frames.
  // A pin bounce during locking sends the machine back to the start.
  always_comb begin
    next_pwr = pwr;
    if (!powered) begin
      next_pwr = scp_down;                                     // [RQ2]
    end else begin
      case (pwr)
        scp_down: next_pwr = scp_lock;
        scp_lock: next_pwr = lock_done ? scp_run : scp_lock;
        scp_run:  next_pwr = scp_run;
        default:  next_pwr = scp_down;
      endcase
    end
  end

  // State register.
  // Reset and power-down land in the same state, so both wake alike.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pwr <= scp_down;
    end else begin
      pwr <= next_pwr;
    end
  end

  // PLL lock counter, cleared whenever not locking.
  // Clearing it outside the lock state restarts the full wait after every wake.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      lock_count <= '0;
    end else if (in_lock & powered & ~lock_done) begin
      lock_count <= lock_count + 8'h01;
    end else begin
      lock_count <= '0;
    end
  end

  // =====================================================================
  // Control register.
  // Held at reset while powered down, loaded from straps on the
  // way out, and afterwards owned by bus writes.
  // A bus write cannot meet the strap load in one cycle: the bus is deaf while down.
  always_comb begin
    next_ctrl = ctrl;
    if (!powered || in_down) begin
      next_ctrl = `SCP_CTRL_RESET;                             // [RQ4]
    end
    if (leave_dn) begin
      next_ctrl = strap_ctrl;                                  // [RQ12]
    end
    if (wr_ctrl) begin
      next_ctrl = {5'h00, bus_wdata[2:0]};                     // [RQ7] [RQ9] [RQ11]
    end
  end

  // Control register storage.
  // The reset value and the power-down value agree, so software sees one default.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl <= `SCP_CTRL_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // =====================================================================
  // Overrun flag.
  // A frame request arriving while the shifter is busy is dropped and
  // noted; a new drop in the clearing cycle keeps the flag set.
  // The power-down clear is applied last, so no flag survives a power cycle.
  always_comb begin
    next_overrun = overrun;
    if (clr_ovr) begin
      next_overrun = 1'b0;
    end
    if (drop) begin
      next_overrun = 1'b1;
    end
    if (!powered || in_down) begin
      next_overrun = 1'b0;                                     // [RQ4]
    end
  end

  // Overrun flag storage.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      overrun <= 1'b0;
    end else begin
      overrun <= next_overrun;
    end
  end

  // =====================================================================
  // Parallel capture and frame shifting.
  // Capture is held off outside the run state, so no word taken while the
  // PLL settles is ever framed.
  scp_capture u_capture (
    .ref_clk           (ref_clk),
    .reset             (reset),
    .hold              (~run_next),
    .parallel_clock_in (parallel_clock_in),
    .edge_rising       (ctrl[`SCP_CTRL_EDGE]),
    .par_data          (par_data),
    .par_ctrl          (par_ctrl),
    .cap_word          (cap_word),
    .cap_valid         (cap_valid)
  );

  // Leaving the run state aborts a frame at once; the legs then sit high.
  // A capture that meets a busy shifter is not loaded and shows as overrun.
  scp_shifter u_shifter (
    .ref_clk (ref_clk),
    .reset   (reset),
    .enable  (run_next),
    .load    (cap_valid),
    .word    (cap_word),
    .ser_bit (ser_bit),
    .busy    (ser_busy)
  );

  // =====================================================================
  // Register read mux.
  // Unmapped offsets read as zero. Reads have no side effects, so
  // software may poll the status at any rate.
  wire [7:0] status = {
    3'h0,
    overrun,
    ser_busy,
    in_run,
    pll_enable,
    ~in_down
  };

  // Captured word split into the byte-wide readback offsets.
  wire [7:0] cap_b0 = cap_word[7:0];
  wire [7:0] cap_b1 = cap_word[15:8];
  wire [7:0] cap_b2 = cap_word[23:16];
  wire [7:0] cap_b3 = {5'h00, cap_word[26:24]};

  // Read data selection by offset.
  always_comb begin
    next_rdata = 8'h00;
    if (bus_rd) begin
      case (bus_addr)
        `SCP_ADDR_CTRL:   next_rdata = ctrl;
        `SCP_ADDR_STATUS: next_rdata = status;
        `SCP_ADDR_CAP0:   next_rdata = cap_b0;
        `SCP_ADDR_CAP1:   next_rdata = cap_b1;
        `SCP_ADDR_CAP2:   next_rdata = cap_b2;
        `SCP_ADDR_CAP3:   next_rdata = cap_b3;
        default:          next_rdata = 8'h00;
      endcase
    end
  end

  // Read data register, valid only in the cycle after the strobe.
  // Without a strobe it falls back to zero, so stale data never lingers.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      bus_rdata <= 8'h00;
    end else begin
      bus_rdata <= next_rdata;
    end
  end

  // =====================================================================
  // Serial outputs and PLL control.
  // Powered down both legs sit high; while locking the line idles low.
  // Each pin value is chosen here and only registered below, so every
  // pin leaves a flip-flop and the driver never sees a decode glitch.
  wire next_out_p = powered ? (in_run & ser_bit) : 1'b1;      // [RQ1] [RQ3]
  wire next_out_n = powered ? ~(in_run & ser_bit) : 1'b1;     // [RQ3]
  wire next_pll   = powered;                                  // [RQ3]
  wire next_link  = powered & in_run;                         // [RQ1] [RQ2]

  // Serial leg registers.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      serial_out_p <= 1'b1;
      serial_out_n <= 1'b1;
    end else begin
      serial_out_p <= next_out_p;
      serial_out_n <= next_out_n;
    end
  end

  // PLL enable and link status registers.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pll_enable  <= 1'b0;
      link_active <= 1'b0;
    end else begin
      pll_enable  <= next_pll;
      link_active <= next_link;
    end
  end

  // Settings follow next_ctrl, so the pins change on the edge that loads
  // the control register.
  wire next_edge   = next_ctrl[`SCP_CTRL_EDGE];               // [RQ7]
  wire next_swing  = next_ctrl[`SCP_CTRL_SWING];              // [RQ8] [RQ9]
  wire next_deemph = next_ctrl[`SCP_CTRL_DEEMPH];             // [RQ11]

  // Settings driven to the analog driver and the capture path.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      edge_rising   <= 1'b0;
      swing_high    <= 1'b0;
      deemph_enable <= 1'b0;
    end else begin
      edge_rising   <= next_edge;
      swing_high    <= next_swing;
      deemph_enable <= next_deemph;
    end
  end

endmodule : scp_top

// ==== src/scp_map.svh ====
// Offsets, field positions, reset values and timing counts of the serializer control block.
// =====================================================================
// Overview of operation
// RQ1 - Power-down input high: transmitter runs normally with the serial link active.
// RQ2 - Power-down input low: transmitter enters its powered-down state.
// RQ3 - Powered down: both serial output legs high and the PLL shut down.
// RQ4 - Powered down: all control registers held at reset, bus settings discarded.
// RQ5 - Edge select high: parallel data and control captured on rising clock edge.
// RQ6 - Edge select low: parallel data and control captured on falling clock edge.
// RQ7 - Capture edge also settable through a bus-written register.
// RQ8 - Swing select high picks the large swing, low the small low-power swing.
// RQ9 - Output swing also settable through a bus-written control register.
// RQ10 - De-emphasis control left floating means de-emphasis disabled; the code has no pull-down and passes the pin on as it stands.
// RQ11 - De-emphasis enabled either by pin strap or by bus-written register.
// RQ12 - After power-down, settings start from pin straps until the bus writes them.
`ifndef SCP_MAP_SVH
`define SCP_MAP_SVH

// =====================================================================
// Register offsets.
`define SCP_ADDR_CTRL   8'h00
`define SCP_ADDR_STATUS 8'h01
`define SCP_ADDR_CAP0   8'h02
`define SCP_ADDR_CAP1   8'h03
`define SCP_ADDR_CAP2   8'h04
`define SCP_ADDR_CAP3   8'h05

// =====================================================================
// Field positions and reset values.
`define SCP_CTRL_EDGE    0
`define SCP_CTRL_SWING   1
`define SCP_CTRL_DEEMPH  2
`define SCP_ST_UP        0
`define SCP_ST_PLL       1
`define SCP_ST_RUN       2
`define SCP_ST_BUSY      3
`define SCP_ST_OVERRUN   4
`define SCP_CTRL_RESET   8'h00

// =====================================================================
// Timing.
`define SCP_CLK_NS       5
`define SCP_PLL_LOCK_NS  1000
`define SCP_PLL_LOCK_CYC ((`SCP_PLL_LOCK_NS + `SCP_CLK_NS - 1) / `SCP_CLK_NS)
`define SCP_FRAME_BITS   28

`endif

// ==== src/scp_pkg.sv ====
// Types shared by the serializer control block.
package scp_pkg;

  // =====================================================================
  // Power sequencing states.
  typedef enum logic [1:0] {
    scp_down,
    scp_lock,
    scp_run
  } scp_pwr_t;

  typedef logic [26:0] scp_word_t;

endpackage : scp_pkg

// ==== src/scp_capture.sv ====
// Parallel input capture on the selected edge of the parallel clock.
`timescale 1ns/1ps
module scp_capture
  import scp_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        hold,
  input  wire logic        parallel_clock_in,
  input  wire logic        edge_rising,
  input  wire logic [23:0] par_data,
  input  wire logic [2:0]  par_ctrl,
  output scp_word_t        cap_word,
  output logic             cap_valid
);

  logic clk_prev;
  wire  rise_seen;
  wire  fall_seen;
  wire  take;

  // Edge detection on the sampled parallel clock.
  assign rise_seen = parallel_clock_in & ~clk_prev;
  assign fall_seen = ~parallel_clock_in & clk_prev;
  assign take      = ~hold & (edge_rising ? rise_seen : fall_seen); // [RQ5] [RQ6]

  // Latch the data and control inputs on the chosen edge.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      clk_prev  <= 1'b0;
      cap_word  <= '0;
      cap_valid <= 1'b0;
    end else begin
      clk_prev  <= parallel_clock_in;
      cap_valid <= take;
      if (take) begin
        cap_word <= {par_ctrl, par_data};
      end
    end
  end

endmodule : scp_capture

// ==== src/scp_shifter.sv ====
// Frame shifter: one start bit followed by the captured word, MSB first.
`timescale 1ns/1ps
`include "scp_map.svh"
module scp_shifter
  import scp_pkg::*;
(
  input  wire logic      ref_clk,
  input  wire logic      reset,
  input  wire logic      enable,
  input  wire logic      load,
  input  scp_word_t      word,
  output logic           ser_bit,
  output logic           busy
);

  localparam logic [4:0] LAST = 5'(`SCP_FRAME_BITS - 1);

  logic [27:0] shreg;
  logic [4:0]  count;
  wire         start;

  // A new frame starts only when idle and enabled.
  assign start = enable & load & ~busy;

  // Shift register and bit counter; disabling aborts a frame.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      shreg   <= '0;
      count   <= '0;
      busy    <= 1'b0;
      ser_bit <= 1'b0;
    end else if (!enable) begin
      shreg   <= '0;
      count   <= '0;
      busy    <= 1'b0;
      ser_bit <= 1'b0;
    end else if (start) begin
      shreg   <= {1'b1, word};
      count   <= '0;
      busy    <= 1'b1;
      ser_bit <= 1'b0;
    end else if (busy) begin
      ser_bit <= shreg[27];
      shreg   <= {shreg[26:0], 1'b0};
      count   <= count + 5'h01;
      busy    <= (count != LAST);
    end else begin
      ser_bit <= 1'b0;
    end
  end

endmodule : scp_shifter

// ==== tb/scp_top_chk.sv ====
// Concurrent checks on the ports of the serializer control block.
`timescale 1ns/1ps
module scp_top_chk (
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic       power_down_n,
  input wire logic       strobe_edge_select,
  input wire logic       swing_select,
  input wire logic       deemphasis_control,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic       bus_wr,
  input wire logic       serial_out_p,
  input wire logic       serial_out_n,
  input wire logic       pll_enable,
  input wire logic       link_active,
  input wire logic       edge_rising,
  input wire logic       swing_high,
  input wire logic       deemph_enable
);
  // ====================================================================
  // Lock phase length, counted while the PLL runs but the link is not up.
  logic [8:0] lock_cnt;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      lock_cnt <= 9'h000;
    end else begin
      lock_cnt <= (pll_enable && !link_active) ? lock_cnt + 9'h001 : 9'h000;
    end
  end

  // All checks share the one clock domain.
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  chk_down_legs_high: assert property (
    !power_down_n |=> serial_out_p && serial_out_n) else $error("serial legs not high in power-down");
  chk_down_pll_off: assert property (
    !power_down_n |=> !pll_enable && !link_active) else $error("pll or link still on in power-down");
  chk_down_regs_clear: assert property (
    !power_down_n |=> !(edge_rising || swing_high || deemph_enable)) else $error("settings kept in power-down");
  chk_wake_from_straps: assert property (
    !pll_enable && power_down_n |=> pll_enable && edge_rising == $past(strobe_edge_select)
    && swing_high == $past(swing_select) && deemph_enable == $past(deemphasis_control))
    else $error("wake settings differ from straps");
  chk_lock_link_low: assert property (
    $rose(pll_enable) |-> !link_active throughout (##197 1)) else $error("link up before lock time");
  chk_lock_time_bound: assert property (
    lock_cnt <= 9'h0cd) else $error("link not up after lock time");
  chk_run_legs_pair: assert property (
    pll_enable |-> serial_out_n == !serial_out_p) else $error("serial legs not complementary");
  chk_bus_ctrl_write: assert property (
    bus_wr && bus_addr == 8'h00 && power_down_n && pll_enable
    |=> {deemph_enable, swing_high, edge_rising} == $past(bus_wdata[2:0])) else $error("control write lost");

  // Main scenarios reached.
  cover property ($rose(link_active));
  cover property (bus_wr && bus_addr == 8'h00 && pll_enable);
  cover property ($fell(power_down_n) && link_active);
endmodule : scp_top_chk

bind scp_top scp_top_chk chk_u (.ref_clk, .reset, .power_down_n, .strobe_edge_select, .swing_select,
  .deemphasis_control, .bus_addr, .bus_wdata, .bus_wr, .serial_out_p, .serial_out_n, .pll_enable,
  .link_active, .edge_rising, .swing_high, .deemph_enable);

// ==== tb/scp_pclk_src.sv ====
// Parallel clock source: one high pulse per request, still low otherwise.
`timescale 1ns/1ps
module scp_pclk_src (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic go,
  output logic      parallel_clock_in
);
  // ====================================================================
  // Long high phase so the block sees both edges well apart.
  logic [3:0] hi_cnt;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      hi_cnt <= 4'h0;
    end else if (go) begin
      hi_cnt <= 4'hc;
    end else if (hi_cnt != 4'h0) begin
      hi_cnt <= hi_cnt - 4'h1;
    end
  end
  assign parallel_clock_in = (hi_cnt != 4'h0);
endmodule : scp_pclk_src

// ==== tb/scp_top_test.sv ====
// Self-checking bench for the serializer control block.
`timescale 1ns/1ps
module scp_top_test;
  import scp_pkg::*;
  // ====================================================================
  // Design signals and counters.
  logic        ref_clk, reset, power_down_n, strobe_edge_select, swing_select, deemphasis_control;
  logic        parallel_clock_in, go, bus_wr, bus_rd, serial_out_p, serial_out_n, pll_enable;
  logic        link_active, edge_rising, swing_high, deemph_enable;
  logic [23:0] par_data;
  logic [2:0]  par_ctrl;
  logic [7:0]  bus_addr, bus_wdata, bus_rdata;
  int          failures, total_checks;

  scp_top dut_u (.ref_clk, .reset, .power_down_n, .strobe_edge_select, .swing_select, .deemphasis_control,
    .parallel_clock_in, .par_data, .par_ctrl, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
    .serial_out_p, .serial_out_n, .pll_enable, .link_active, .edge_rising, .swing_high, .deemph_enable);
  scp_pclk_src src_u (.ref_clk, .reset, .go, .parallel_clock_in);

  // Free-running 200 MHz reference clock.
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Compares and counts; a mismatch is reported at once.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Expected values worked out from the rules.
  function automatic logic [26:0] exp_word(input logic rising, input logic [26:0] a, input logic [26:0] b);
    return rising ? a : b;
  endfunction : exp_word

  function automatic logic [3:0] exp_wake(input logic [2:0] s);
    return {s, 1'b1};
  endfunction : exp_wake

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  // Register port cycles: one-cycle strobes, read data in the next cycle.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    #1;
    d = bus_rdata;
  endtask : rd

  // Power-down with a write that must be lost, then wake on new straps.
  task automatic pwr_cycle(input logic [2:0] s);
    logic [7:0] d;
    int         n;
    @(posedge ref_clk);
    power_down_n <= 1'b0;
    {deemphasis_control, swing_select, strobe_edge_select} <= s;
    repeat (2) @(posedge ref_clk);
    #1;
    check({serial_out_p, serial_out_n, pll_enable, link_active}, 4'hc);
    wr(8'h00, 8'h07);
    rd(8'h00, d);
    check(d, 8'h00);
    @(posedge ref_clk);
    power_down_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    check({deemph_enable, swing_high, edge_rising, pll_enable}, exp_wake(s));
    for (n = 0; link_active !== 1'b1; n++) begin
      @(posedge ref_clk);
      #1;
      if (n > 260) begin
        failures++;
        end_sim();
      end
    end
  endtask : pwr_cycle

  // One parallel clock pulse; data changes between its edges, so the frame shows the capture edge.
  task automatic frame(input logic rising);
    logic [26:0] a, b, got, e;
    logic [7:0]  d;
    int          n;
    a = 27'($urandom);
    b = 27'($urandom);
    @(posedge ref_clk);
    {par_ctrl, par_data} <= a;
    go <= 1'b1;
    for (n = 0; serial_out_p !== 1'b1; n++) begin
      @(posedge ref_clk);
      if (n == 0) go <= 1'b0;
      if (n == 7) {par_ctrl, par_data} <= b;
      #1;
      if (n > 80) begin
        failures++;
        end_sim();
      end
    end
    for (n = 26; n >= 0; n--) begin
      @(posedge ref_clk);
      #1;
      got[n] = serial_out_p;
    end
    e = exp_word(rising, a, b);
    check(got, e);
    for (n = 0; n < 4; n++) begin
      rd(8'(n + 2), d);
      check(d, 8'(e >> (8 * n)));
    end
    repeat (8) @(posedge ref_clk);
  endtask : frame

  // Two captures closer than one frame: the second is dropped and flagged, then cleared by writing one.
  task automatic burst();
    logic [7:0] d;
    @(posedge ref_clk);
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    repeat (13) @(posedge ref_clk);
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    repeat (60) @(posedge ref_clk);
    rd(8'h01, d);
    check(d[4:3], 2'h2);
    wr(8'h01, 8'h10);
    rd(8'h01, d);
    check(d[4:3], 2'h0);
  endtask : burst

  // Main sequence: strap edges, then the opposite edge through the register.
  initial begin
    logic [2:0] s, w;
    logic [7:0] d;
    {power_down_n, go, bus_wr, bus_rd, bus_addr, bus_wdata, par_data, par_ctrl} = '0;
    {strobe_edge_select, swing_select, deemphasis_control} = 3'h0;
    reset = 1'b1;
    void'($urandom(32'hc61b));
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      s = (i == 0) ? 3'h0 : 3'($urandom);
      s[0] = i[0];
      pwr_cycle(s);
      frame(s[0]);
      w = {2'($urandom), ~s[0]};
      wr(8'h00, {5'h00, w});
      rd(8'h00, d);
      check(d, {5'h00, w});
      check({deemph_enable, swing_high, edge_rising}, w);
      frame(w[0]);
      burst();
      rd(8'h01, d);
      check(d[2:0], 3'h7);
      $display("power cycle %0d done", i);
    end
    rd(8'h80, d);
    check(d, 8'h00);
    end_sim();
  end
endmodule : scp_top_test
